/* rtl/pfp_map.vh */
// Offsets, fields, reset values and tables of the program flash protection block
`ifndef PFP_MAP_VH
`define PFP_MAP_VH

// Register byte addresses
`define PFP_OFF_PROT 8'h08
`define PFP_OFF_STAT 8'h0c

// Protection register fields
`define PFP_BIT_POL 7
`define PFP_BIT_RSV 6
`define PFP_BIT_HDIS 5
`define PFP_BIT_HS_HI 4
`define PFP_BIT_HS_LO 3
`define PFP_BIT_LDIS 2
`define PFP_BIT_LS_HI 1
`define PFP_BIT_LS_LO 0

// Status register fields
`define PFP_BIT_VIOL 4
`define PFP_BIT_LOADED 0

// Value held before the load and after a double bit fault
`define PFP_FULL_PROT 8'h7f

// Configuration byte location
`define PFP_CFG_ADDR 23'h7f_ff0c

// Program array bounds
`define PFP_ARRAY_BASE 23'h7e_0000
`define PFP_ARRAY_TOP 23'h7f_ffff

// Upper range starts, by size code
`define PFP_HI_START0 23'h7f_f800
`define PFP_HI_START1 23'h7f_f000
`define PFP_HI_START2 23'h7f_e000
`define PFP_HI_START3 23'h7f_c000

// Lower range bounds, by size code
`define PFP_LO_BASE 23'h7f_8000
`define PFP_LO_END0 23'h7f_83ff
`define PFP_LO_END1 23'h7f_87ff
`define PFP_LO_END2 23'h7f_8fff
`define PFP_LO_END3 23'h7f_9fff

// Allowed scenario transitions, one byte per source, bit n allows target n
`define PFP_TRANS_MAP 64'hff5a_3c18_080c_0a0f

`endif

/* rtl/pfp_prot.v */
// Program flash protection register with AHB-Lite access and address checker
// Behaviour
// - Reset sequence loads the register from the stored byte at 0x7F_FF0C.
// - Double bit fault at load clears polarity bit, sets all others.
// - A write giving a scenario not allowed from the current one is ignored.
// - Reads always return the protection actually in force.
// - Program or erase to a protected address is refused, violation flag set.
// - Block erase refused while any sector of the block is protected.
// - Bit 7 sets range polarity: 1 ranges protected, 0 ranges unprotected.
// - Both ranges disabled: nothing protected if bit 7 set, else all.
// - Bit 5 disables the upper range ending at 0x7F_FFFF.
// - Upper size bits 4-3 take writes only while the upper range is disabled.
// - Upper size codes give 2, 4, 8, 16 Kbytes ending at the array top.
// - Bit 2 disables the lower range starting at 0x7F_8000.
// - Lower size bits 1-0 take writes only while the lower range is disabled.
// - Lower size codes give 1, 2, 4, 8 Kbytes from 0x7F_8000.
// - An eight by eight matrix of scenario transitions is enforced.
// - After the load, software may change protection under add-only limits.
// - Violation flag clears only by writing 1; while set, commands blocked.
`timescale 1ns/1ps
`include "pfp_map.vh"

module pfp_prot (
  input wire clk_i,
  input wire srst_i,
  // AHB-Lite slave
  input wire hsel_i,
  input wire [31:0] haddr_i,
  input wire [1:0] htrans_i,
  input wire hwrite_i,
  input wire [2:0] hsize_i,
  input wire [31:0] hwdata_i,
  input wire hready_i,
  output reg [31:0] hrdata_o,
  output wire hreadyout_o,
  output wire hresp_o,
  // Reset sequence load
  output wire cfg_req_o,
  output wire [22:0] cfg_addr_o,
  input wire cfg_valid_i,
  input wire [7:0] cfg_byte_i,
  input wire cfg_dbf_i,
  // Command engine check
  input wire chk_valid_i,
  input wire [22:0] chk_addr_i,
  input wire chk_blk_erase_i,
  output wire chk_prot_o,
  output wire chk_refuse_o,
  output wire launch_block_o,
  // State
  output reg [7:0] prot_o,
  output reg viol_o
);

  // Scenario number of a register value
  function [2:0] pfp_scen;
    input [7:0] v;
    begin
      pfp_scen = {v[`PFP_BIT_POL], v[`PFP_BIT_HDIS], v[`PFP_BIT_LDIS]};
    end
  endfunction

  // Transition matrix lookup
  function pfp_allowed;
    input [2:0] from;
    input [2:0] to;
    reg [63:0] map;
    begin
      map = `PFP_TRANS_MAP;
      pfp_allowed = map[{from, to}];
    end
  endfunction

  // Whether a program address is protected under a register value
  function pfp_is_prot;
    input [7:0] v;
    input [22:0] a;
    reg [22:0] hi_start;
    reg [22:0] lo_end;
    reg in_hi;
    reg in_lo;
    reg in_rng;
    reg in_arr;
    begin
      case (v[`PFP_BIT_HS_HI:`PFP_BIT_HS_LO])
        2'b00: hi_start = `PFP_HI_START0;
        2'b01: hi_start = `PFP_HI_START1;
        2'b10: hi_start = `PFP_HI_START2;
        default: hi_start = `PFP_HI_START3;
      endcase
      case (v[`PFP_BIT_LS_HI:`PFP_BIT_LS_LO])
        2'b00: lo_end = `PFP_LO_END0;
        2'b01: lo_end = `PFP_LO_END1;
        2'b10: lo_end = `PFP_LO_END2;
        default: lo_end = `PFP_LO_END3;
      endcase
      // Upper range ends at the array top
      in_hi = (a >= hi_start) && (a <= `PFP_ARRAY_TOP);
      in_lo = (a >= `PFP_LO_BASE) && (a <= lo_end);
      in_rng = (~v[`PFP_BIT_HDIS] & in_hi)
             | (~v[`PFP_BIT_LDIS] & in_lo);
      in_arr = (a >= `PFP_ARRAY_BASE) && (a <= `PFP_ARRAY_TOP);
      // Polarity picks ranges or their complement
      if (v[`PFP_BIT_POL]) begin
        pfp_is_prot = in_arr & in_rng;
      end else begin
        pfp_is_prot = in_arr & ~in_rng;
      end
    end
  endfunction

  reg loaded;
  reg dp_valid;
  reg dp_write;
  reg [7:0] dp_addr;
  reg [7:0] next_prot;
  reg next_viol;
  reg [7:0] wr_val;
  reg [31:0] next_rdata;
  wire ap_valid;
  wire wr_prot;
  wire wr_stat;
  wire blk_prot;
  wire refuse;

  // Zero wait state, always OKAY
  assign hreadyout_o = 1'b1;
  assign hresp_o = 1'b0;

  assign ap_valid = hsel_i & htrans_i[1] & hready_i;

  // Address phase capture
  always @(posedge clk_i) begin
    if (srst_i) begin
      dp_valid <= 1'b0;
      dp_write <= 1'b0;
      dp_addr <= 8'h00;
    end else begin
      dp_valid <= ap_valid;
      dp_write <= hwrite_i;
      dp_addr <= haddr_i[7:0];
    end
  end

  assign wr_prot = dp_valid & dp_write & (dp_addr == `PFP_OFF_PROT);
  assign wr_stat = dp_valid & dp_write & (dp_addr == `PFP_OFF_STAT);

  // Fetch of the stored byte stays requested until it arrives
  assign cfg_req_o = ~loaded;
  assign cfg_addr_o = `PFP_CFG_ADDR;

  // Size fields keep their value while their range is enabled
  always @* begin
    wr_val = hwdata_i[7:0];
    if (!prot_o[`PFP_BIT_HDIS]) begin
      wr_val[`PFP_BIT_HS_HI:`PFP_BIT_HS_LO] =
        prot_o[`PFP_BIT_HS_HI:`PFP_BIT_HS_LO];
    end
    if (!prot_o[`PFP_BIT_LDIS]) begin
      wr_val[`PFP_BIT_LS_HI:`PFP_BIT_LS_LO] =
        prot_o[`PFP_BIT_LS_HI:`PFP_BIT_LS_LO];
    end
  end

  // Protection register next value
  always @* begin
    next_prot = prot_o;
    if (!loaded) begin
      if (cfg_valid_i) begin
        if (cfg_dbf_i) begin
          next_prot = `PFP_FULL_PROT;
        end else begin
          next_prot = cfg_byte_i;
        end
      end
    end else if (wr_prot) begin
      // Writes before the load are dropped; the load owns the register
      if (pfp_allowed(pfp_scen(prot_o), pfp_scen(wr_val))) begin
        next_prot = wr_val;
      end
    end
  end

  // Checker outputs
  assign chk_prot_o = pfp_is_prot(prot_o, chk_addr_i);
  // Any range enabled, or inverted polarity, leaves some sector protected
  assign blk_prot = ~prot_o[`PFP_BIT_POL]
                  | ~prot_o[`PFP_BIT_HDIS]
                  | ~prot_o[`PFP_BIT_LDIS];
  assign refuse = chk_blk_erase_i ? blk_prot : chk_prot_o;
  assign chk_refuse_o = refuse;
  assign launch_block_o = viol_o;

  // Violation flag: a new event wins over a clear in the same cycle
  always @* begin
    next_viol = viol_o;
    if (wr_stat && hwdata_i[`PFP_BIT_VIOL]) begin
      next_viol = 1'b0;
    end
    if (chk_valid_i && refuse) begin
      next_viol = 1'b1;
    end
  end

  always @(posedge clk_i) begin
    if (srst_i) begin
      prot_o <= `PFP_FULL_PROT;
      viol_o <= 1'b0;
      loaded <= 1'b0;
    end else begin
      prot_o <= next_prot;
      viol_o <= next_viol;
      if (cfg_valid_i) begin
        loaded <= 1'b1;
      end
    end
  end

  // Read data taken from next values so a read right after a write sees it
  always @* begin
    next_rdata = 32'h0000_0000;
    if (ap_valid && !hwrite_i) begin
      case (haddr_i[7:0])
        `PFP_OFF_PROT: begin
          next_rdata[7:0] = next_prot;
        end
        `PFP_OFF_STAT: begin
          next_rdata[`PFP_BIT_VIOL] = next_viol;
          next_rdata[`PFP_BIT_LOADED] = loaded | cfg_valid_i;
        end
        default: begin
          next_rdata = 32'h0000_0000;
        end
      endcase
    end
  end

  always @(posedge clk_i) begin
    if (srst_i) begin
      hrdata_o <= 32'h0000_0000;
    end else begin
      hrdata_o <= next_rdata;
    end
  end

endmodule

/* verif/pfp_prot_sva.sv */
// Assertion checker for the program flash protection block
`timescale 1ns/1ps
module pfp_prot_chk (
  input wire clk_i,
  input wire srst_i,
  input wire hsel_i,
  input wire [31:0] haddr_i,
  input wire [1:0] htrans_i,
  input wire hwrite_i,
  input wire hready_i,
  input wire [31:0] hwdata_i,
  input wire [31:0] hrdata_o,
  input wire cfg_req_o,
  input wire cfg_valid_i,
  input wire [7:0] cfg_byte_i,
  input wire cfg_dbf_i,
  input wire chk_valid_i,
  input wire [22:0] chk_addr_i,
  input wire chk_blk_erase_i,
  input wire chk_prot_o,
  input wire chk_refuse_o,
  input wire launch_block_o,
  input wire [7:0] prot_o,
  input wire viol_o
);
  reg wp_q;
  reg ws_q;
  reg rp_q;
  wire ap = hsel_i & htrans_i[1] & hready_i;
  wire arr = chk_addr_i[22:17] == 6'h3f;
  always @(posedge clk_i) begin
    wp_q <= ap & hwrite_i & (haddr_i[7:0] == 8'h08);
    ws_q <= ap & hwrite_i & (haddr_i[7:0] == 8'h0c);
    rp_q <= ap & !hwrite_i & (haddr_i[7:0] == 8'h08);
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (srst_i);
  load_val_a: assert property (cfg_req_o && cfg_valid_i
    |=> !cfg_req_o && prot_o == ($past(cfg_dbf_i) ? 8'h7f : $past(cfg_byte_i))) else $error("load value");
  prot_hold_a: assert property (!$stable(prot_o) |-> $past(wp_q) || $past(cfg_valid_i))
    else $error("protection changed unasked");
  prot_read_a: assert property (rp_q |-> hrdata_o == {24'h0, prot_o}) else $error("read value");
  viol_set_a: assert property (chk_valid_i && chk_refuse_o |=> viol_o) else $error("violation lost");
  viol_clear_a: assert property ($fell(viol_o) |-> $past(ws_q) && $past(hwdata_i[4]))
    else $error("violation dropped");
  launch_block_a: assert property (launch_block_o == viol_o) else $error("launch block");
  erase_block_a: assert property (chk_blk_erase_i && arr
    |-> chk_refuse_o == (!prot_o[7] || !prot_o[5] || !prot_o[2])) else $error("block erase");
  none_prot_a: assert property (prot_o[7] && prot_o[5] && prot_o[2] |-> !chk_prot_o)
    else $error("open array protected");
  full_prot_a: assert property (!prot_o[7] && prot_o[5] && prot_o[2] && arr |-> chk_prot_o)
    else $error("full protection missing");
endmodule

/* verif/tb_pfp_prot.sv */
// Self-checking bench for the program flash protection block
`timescale 1ns/1ps
`include "pfp_map.vh"
module tb_pfp_prot;
  reg clk_i = 0, srst_i = 1, hsel_i = 0, hwrite_i = 0, cfg_valid_i = 0, cfg_dbf_i = 0;
  reg chk_valid_i = 0, chk_blk_erase_i = 0, rd_dp = 0, ev = 0;
  reg [1:0] htrans_i = 0;
  reg [31:0] haddr_i = 0, hwdata_i = 0, rnd = 32'h99ee;
  reg [7:0] cfg_byte_i = 0, cur, w;
  reg [22:0] chk_addr_i = 0;
  wire [31:0] hrdata_o;
  wire hreadyout_o, hresp_o, cfg_req_o, chk_prot_o, chk_refuse_o, launch_block_o, viol_o;
  wire [22:0] cfg_addr_o;
  wire [7:0] prot_o;
  reg [31:0] qr[$];
  reg [1:0] qc[$];
  integer n_mismatch = 0, total_checks = 0, cyc = 0, i, j;
  pfp_prot dut (.*, .hready_i(hreadyout_o), .hsize_i(3'b010));
  initial forever #4 clk_i = ~clk_i;
  function [31:0] xs(input [31:0] x);
    begin
      x = x ^ (x << 13);
      x = x ^ (x >> 17);
      xs = x ^ (x << 5);
    end
  endfunction
  // Rejected writes keep everything; size fields move only while their range is off
  function [7:0] nxt(input [7:0] o, input [7:0] v);
    reg [63:0] m;
    begin
      m = `PFP_TRANS_MAP;
      nxt = o;
      if (m[{o[7], o[5], o[2], v[7], v[5], v[2]}]) begin
        nxt = v;
        if (!o[5]) nxt[4:3] = o[4:3];
        if (!o[2]) nxt[1:0] = o[1:0];
      end
    end
  endfunction
  function pr(input [7:0] v, input [22:0] a);
    reg r;
    begin
      r = !v[5] && {1'b0, a} >= 24'h80_0000 - (24'h800 << v[4:3]);
      r = r || (!v[2] && a >= 23'h7f_8000 && a < 23'h7f_8000 + (23'h400 << v[1:0]));
      pr = a[22:17] == 6'h3f && (v[7] ? r : !r);
    end
  endfunction
  task cmp_word(input [31:0] g, input [31:0] e);
    begin
      total_checks = total_checks + 1;
      if (g !== e) begin
        n_mismatch = n_mismatch + 1;
        $display("MISMATCH %0t read %h expected %h", $time, g, e);
      end
    end
  endtask
  task cmp_flags(input [1:0] g, input [1:0] e);
    begin
      total_checks = total_checks + 1;
      if (g !== e) begin
        n_mismatch = n_mismatch + 1;
        $display("MISMATCH %0t check flags %b expected %b", $time, g, e);
      end
    end
  endtask
  task tally_and_finish;
    begin
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
    end
  endtask
  // Idle cycle at the end so the next request never lands in the same step
  task bus(input wr, input [7:0] a, input [31:0] d);
    begin
      hsel_i <= 1;
      htrans_i <= 2'b10;
      haddr_i <= {24'h0, a};
      hwrite_i <= wr;
      do @(posedge clk_i); while (hreadyout_o !== 1'b1);
      htrans_i <= 0;
      hwdata_i <= d;
      rd_dp <= !wr;
      do @(posedge clk_i); while (hreadyout_o !== 1'b1);
      hsel_i <= 0;
      rd_dp <= 0;
      @(posedge clk_i);
    end
  endtask
  task rd(input [7:0] a, input [31:0] e);
    begin
      qr.push_back(e);
      bus(0, a, 0);
    end
  endtask
  // Expected flags kept locally: the watcher may pop the queue at the same edge
  task chk(input [22:0] a, input b);
    reg [1:0] e;
    begin
      e = {b ? (!cur[7] || !cur[5] || !cur[2]) : pr(cur, a), pr(cur, a)};
      qc.push_back(e);
      chk_valid_i <= 1;
      chk_addr_i <= a;
      chk_blk_erase_i <= b;
      @(posedge clk_i);
      chk_valid_i <= 0;
      ev = ev | e[1];
      @(posedge clk_i);
    end
  endtask
  task boot(input [7:0] b, input f);
    begin
      srst_i <= 1;
      repeat (3) @(posedge clk_i);
      srst_i <= 0;
      ev = 0;
      @(posedge clk_i);
      cmp_word({9'h0, cfg_addr_o}, {9'h0, `PFP_CFG_ADDR});
      // Stored byte only changes between boots, always with reserved bit 6 set
      cfg_valid_i <= 1;
      cfg_byte_i <= b;
      cfg_dbf_i <= f;
      @(posedge clk_i);
      cfg_valid_i <= 0;
      cur = f ? 8'h7f : b;
      @(posedge clk_i);
    end
  endtask
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (rd_dp) cmp_word(hrdata_o, qr.pop_front());
    if (chk_valid_i) cmp_flags({chk_refuse_o, chk_prot_o}, qc.pop_front());
    if (cyc > 20000) begin
      n_mismatch = n_mismatch + 1;
      tally_and_finish;
    end
  end
  initial begin
    repeat (3) @(posedge clk_i);
    srst_i <= 0;
    @(posedge clk_i);
    bus(1, `PFP_OFF_PROT, 32'hff);
    rd(`PFP_OFF_PROT, 32'h7f);
    rd(`PFP_OFF_STAT, 32'h0);
    boot(8'hc3, 1);
    rd(`PFP_OFF_PROT, 32'h7f);
    // Every source and target scenario pair, random sizes, reserved bit held at 1
    for (i = 0; i < 64; i = i + 1) begin
      rnd = xs(rnd);
      boot({i[5], 1'b1, i[4], rnd[4:3], i[3], rnd[1:0]}, 0);
      rd(`PFP_OFF_STAT, 32'h1);
      w = {i[2], 1'b1, i[1], rnd[12:11], i[0], rnd[9:8]};
      bus(1, `PFP_OFF_PROT, {rnd[31:24], 16'h0, w});
      cur = nxt(cur, w);
      rd(`PFP_OFF_PROT, {24'h0, cur});
      for (j = 0; j < 4; j = j + 1) begin
        rnd = xs(rnd);
        chk(j[0] ? {8'hff, rnd[14:0]} : {6'h3f, rnd[16:0]}, j == 3);
      end
      rd(`PFP_OFF_STAT, {27'h0, ev, 4'h1});
      cmp_flags({hresp_o, launch_block_o}, {1'b0, ev});
      bus(1, `PFP_OFF_STAT, 32'h10);
      ev = 0;
      rd(`PFP_OFF_STAT, 32'h1);
      rd(8'h04, 32'h0);
    end
    tally_and_finish;
  end
endmodule
bind pfp_prot pfp_prot_chk u_chk (.*);
